// file: rtl/rcs_pkg.sv
/*
  Shared constants for the reset-cause and start-up sequencer: register
  map, field positions, reset values, timing counts and sequencer states.
  Assumes a single 10 MHz clock and an 8-bit register port.
*/
package rcs_pkg;
  localparam int CLK_HZ = 10000000;
  // Power-up timer, nominal time in ms
  localparam int POWERUP_TIME_MS = 64;
  localparam int POWERUP_DEF_CYCLES = (POWERUP_TIME_MS * (CLK_HZ / 1000) < 1) ? 1 :
                                      POWERUP_TIME_MS * (CLK_HZ / 1000);
  // Oscillator start-up count, plain default
  localparam int OST_CYCLES = 1024;

  localparam int REG_AW = 2;
  localparam int REG_DW = 8;
  localparam logic [REG_AW-1:0] ADDR_FLAGS = 2'h0;
  localparam logic [REG_AW-1:0] ADDR_STATUS = 2'h1;
  localparam logic [REG_AW-1:0] ADDR_INT_STAT = 2'h2;
  localparam logic [REG_AW-1:0] ADDR_INT_MASK = 2'h3;

  // Cause flag positions
  localparam int FLG_OVF = 7;
  localparam int FLG_UNF = 6;
  localparam int FLG_PIN_N = 3;
  localparam int FLG_INSTR_N = 2;
  localparam int FLG_POR_N = 1;
  localparam int FLG_BROWN_N = 0;
  localparam logic [REG_DW-1:0] FLAGS_IMPL_MASK = 8'hCF;
  localparam logic [REG_DW-1:0] FLAGS_POR_VALUE = 8'h0C;

  // Status bit positions
  localparam int STAT_TO_N = 4;
  localparam int STAT_DOWN_N = 3;

  // Interrupt event positions
  localparam int INT_W = 7;
  localparam int EV_START = 0;
  localparam int EV_PIN = 1;
  localparam int EV_WDT = 2;
  localparam int EV_INSTR = 3;
  localparam int EV_STACK = 4;
  localparam int EV_WAKE = 5;
  localparam int EV_BROWN = 6;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_VECTOR = 16'h0004;

  typedef enum logic [2:0] {
    ST_POWER = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } rcs_state_type;
endpackage

// file: rtl/rcs_timer_if.sv
/*
  Handshake between the sequencer and one start-up timer.
  Assumes both ends share the sequencer clock.
*/
`timescale 1ns/1ns
interface rcs_timer_if;
  logic start;
  logic enable;
  logic done;
  modport ctrl(output start, output enable, input done);
  modport timer(input start, input enable, output done);
endinterface

// file: rtl/rcs_startup_timer.sv
/*
  One start-up down-counter; done when expired or when not enabled.
  Assumes start is a pulse from the sequencer on the same clock.
*/
`timescale 1ns/1ns
module rcs_startup_timer #(
  parameter int CNT_W = 20,
  parameter logic [CNT_W-1:0] COUNT = 20'h00400
) (
  input wire logic ref_clk,
  input wire logic reset,
  rcs_timer_if.timer tif
);
  logic [CNT_W-1:0] count_r;
  logic running_r;
  logic expired_r;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_r <= '0;
      running_r <= 1'b0;
      expired_r <= 1'b0;
    end else if (tif.start) begin
      count_r <= COUNT - CNT_W'(1);
      running_r <= 1'b1;
      expired_r <= 1'b0;
    end else if (running_r) begin
      if (count_r == '0) begin
        running_r <= 1'b0;
        expired_r <= 1'b1;
      end else begin
        count_r <= count_r - CNT_W'(1);
      end
    end
  end

  assign tif.done = !tif.enable || expired_r;

  // A fresh start hides an earlier expiry whenever the timer is enabled
  a_start_clears_done: assert property (@(posedge ref_clk) disable iff (reset)
    tif.start && tif.enable |=> !tif.done)
    else $error("timer done right after start");
endmodule

// file: rtl/rcs_reset_cause_startup.sv
/*
  Start-up gating and reset-cause recording: holds the core until the
  power-up timer, oscillator start-up timer and external reset pin allow it,
  and keeps the cause flags and status bits for firmware.
  Assumes core event inputs are one-cycle pulses on ref_clk; supply and pin
  levels are asynchronous and synchronised here.
*/
`timescale 1ns/1ns
// What this block does
// - Run only after enabled timers expire and, if pin reset enabled, pin high
// - Timers ignore pin; release runs at once
// - Power-on sets both status bits, restarts zero
// - Power-on loads cause flags with fixed pattern
// - Brown-out clears its flag, stack flags; restart
// - Pin reset clears pin flag; sleep adjusts status
// - Reset instruction clears its flag, restarts zero
// - Watchdog clears time-out; wake continues next
// - Interrupt wake resumes, then vectors if enabled
// - Enabled stack faults set flag and restart
// - Firmware may write every cause flag
// - Unimplemented bits read as zero
// - Stack resets need the enable bit
// - Timers start after power and brown-out release
module rcs_reset_cause_startup
  import rcs_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_DEF_CYCLES,
  parameter int OSC_START_CYCLES = OST_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [REG_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_DW-1:0] regRdata,
  input wire logic porActive,
  input wire logic brownoutActive,
  input wire logic external_reset_pin_n,
  input wire logic pinResetEnable,
  input wire logic powerup_timer_en,
  input wire logic oscStartRequired,
  input wire logic stack_reset_enable,
  input wire logic global_irq_enable,
  input wire logic sleepActive,
  input wire logic wdtExpire,
  input wire logic resetInstr,
  input wire logic stackOverflow,
  input wire logic stackUnderflow,
  input wire logic irqWake,
  output logic coreHold,
  output logic pcLoad,
  output logic [15:0] pcLoadAddr,
  output logic resumeNext,
  output logic timeout_status_n,
  output logic powerdown_status_n,
  output logic irq
);
  localparam int PT_W = $clog2(POWERUP_CYCLES + 1);
  localparam int OT_W = $clog2(OSC_START_CYCLES + 1);

  rcs_state_type state_r;
  rcs_state_type state_nxt;
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  logic porS, brownS, pinS;
  logic pinPrev_r;
  logic pinLow, startOk, running;
  logic porEvt, brownEvt, pinEvt, instrEvt, wdtEvt, wakeEvt, ovfEvt, unfEvt;
  logic flagWr;
  logic [REG_DW-1:0] flags_r;
  logic toStat_r, downStat_r;
  logic [INT_W-1:0] intStat_r, intMask_r, intEvt;
  logic vectorPend_r;
  logic [REG_DW-1:0] regRdata_r;
  logic pcLoad_r, resume_r;
  logic [15:0] pcAddr_r;

  rcs_timer_if ptIf();
  rcs_timer_if ostIf();

  rcs_startup_timer #(.CNT_W(PT_W), .COUNT(PT_W'(POWERUP_CYCLES))) powerupTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .tif(ptIf)
  );

  rcs_startup_timer #(.CNT_W(OT_W), .COUNT(OT_W'(OSC_START_CYCLES))) oscTimer (
    .ref_clk(ref_clk),
    .reset(reset),
    .tif(ostIf)
  );

  // Supply and pin levels arrive asynchronously
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syncA_r <= 3'h4;
      syncB_r <= 3'h4;
    end else begin
      syncA_r <= {external_reset_pin_n, brownoutActive, porActive};
      syncB_r <= syncA_r;
    end
  end
  assign porS = syncB_r[0];
  assign brownS = syncB_r[1];
  assign pinS = syncB_r[2];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinPrev_r <= 1'b1;
    end else begin
      pinPrev_r <= pinS;
    end
  end

  assign pinLow = pinResetEnable && !pinS;
  // Timers run whatever the pin does, so release needs no extra wait
  assign startOk = ptIf.done && ostIf.done && !pinLow;
  assign ptIf.start = (state_r == ST_POWER) && !porS && !brownS;
  assign ostIf.start = ptIf.start;
  assign ptIf.enable = powerup_timer_en;
  assign ostIf.enable = oscStartRequired;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POWER: begin
        if (!porS && !brownS) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (porS || brownS) begin
          state_nxt = ST_POWER;
        end else if (startOk) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (porS || brownS) begin
          state_nxt = ST_POWER;
        end
      end
      default: state_nxt = ST_POWER;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_POWER;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign running = (state_r == ST_RUN) && !pinLow;
  assign coreHold = !running;

  // Core events only count while the core runs
  assign porEvt = porS;
  assign brownEvt = brownS && !porS;
  assign pinEvt = (state_r == ST_RUN) && pinResetEnable && pinPrev_r && !pinS;
  assign instrEvt = running && resetInstr;
  assign wdtEvt = running && wdtExpire;
  assign wakeEvt = running && sleepActive && irqWake;
  assign ovfEvt = running && stackOverflow && stack_reset_enable;
  assign unfEvt = running && stackUnderflow && stack_reset_enable;
  assign flagWr = regWr && (regAddr == ADDR_FLAGS);

  // Hardware updates come after the firmware write, so an event wins
  always_ff @(posedge ref_clk) begin
    if (reset || porEvt) begin
      flags_r <= FLAGS_POR_VALUE;
    end else begin
      if (flagWr) begin
        flags_r <= regWdata & FLAGS_IMPL_MASK;
      end
      if (brownEvt) begin
        flags_r[FLG_OVF] <= 1'b0;
        flags_r[FLG_UNF] <= 1'b0;
        flags_r[FLG_PIN_N] <= 1'b1;
        flags_r[FLG_INSTR_N] <= 1'b1;
        flags_r[FLG_BROWN_N] <= 1'b0;
      end
      if (pinEvt) begin
        flags_r[FLG_PIN_N] <= 1'b0;
      end
      if (instrEvt) begin
        flags_r[FLG_INSTR_N] <= 1'b0;
      end
      if (ovfEvt) begin
        flags_r[FLG_OVF] <= 1'b1;
      end
      if (unfEvt) begin
        flags_r[FLG_UNF] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || porEvt) begin
      toStat_r <= 1'b1;
      downStat_r <= 1'b1;
    end else if (brownEvt) begin
      toStat_r <= 1'b1;
      downStat_r <= 1'b1;
    end else if (wdtEvt) begin
      toStat_r <= 1'b0;
      if (sleepActive) begin
        downStat_r <= 1'b0;
      end
    end else if ((pinEvt && sleepActive) || wakeEvt) begin
      toStat_r <= 1'b1;
      downStat_r <= 1'b0;
    end
  end
  assign timeout_status_n = toStat_r;
  assign powerdown_status_n = downStat_r;

  // Restart to zero, resume after sleep, or vector after an interrupt wake
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pcLoad_r <= 1'b0;
      resume_r <= 1'b0;
      vectorPend_r <= 1'b0;
      pcAddr_r <= PC_RESET;
    end else begin
      pcLoad_r <= 1'b0;
      resume_r <= 1'b0;
      vectorPend_r <= 1'b0;
      if (state_r != ST_RUN && state_nxt == ST_RUN) begin
        pcLoad_r <= 1'b1;
        pcAddr_r <= PC_RESET;
      end else if (state_r == ST_RUN && pinResetEnable && !pinPrev_r && pinS) begin
        pcLoad_r <= 1'b1;
        pcAddr_r <= PC_RESET;
      end else if (instrEvt || ovfEvt || unfEvt || (wdtEvt && !sleepActive)) begin
        pcLoad_r <= 1'b1;
        pcAddr_r <= PC_RESET;
      end else if ((wdtEvt && sleepActive) || wakeEvt) begin
        resume_r <= 1'b1;
        vectorPend_r <= wakeEvt && global_irq_enable;
      end else if (vectorPend_r && running) begin
        pcLoad_r <= 1'b1;
        pcAddr_r <= PC_VECTOR;
      end
    end
  end
  assign pcLoad = pcLoad_r;
  assign resumeNext = resume_r;
  assign pcLoadAddr = pcAddr_r;

  assign intEvt = {brownEvt, (wdtEvt && sleepActive) || wakeEvt, ovfEvt || unfEvt,
                   instrEvt, wdtEvt, pinEvt, state_r == ST_WAIT && state_nxt == ST_RUN};

  // Write one to clear; a new event in the same cycle stays set
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      intStat_r <= '0;
    end else if (regWr && regAddr == ADDR_INT_STAT) begin
      intStat_r <= (intStat_r & ~regWdata[INT_W-1:0]) | intEvt;
    end else begin
      intStat_r <= intStat_r | intEvt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      intMask_r <= '0;
    end else if (regWr && regAddr == ADDR_INT_MASK) begin
      intMask_r <= regWdata[INT_W-1:0];
    end
  end
  assign irq = |(intStat_r & intMask_r);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regRdata_r <= '0;
    end else if (regRd) begin
      case (regAddr)
        ADDR_FLAGS: regRdata_r <= flags_r & FLAGS_IMPL_MASK;
        ADDR_STATUS: regRdata_r <= REG_DW'({toStat_r, downStat_r}) << STAT_DOWN_N;
        ADDR_INT_STAT: regRdata_r <= {1'b0, intStat_r};
        ADDR_INT_MASK: regRdata_r <= {1'b0, intMask_r};
        default: regRdata_r <= '0;
      endcase
    end else begin
      regRdata_r <= '0;
    end
  end
  assign regRdata = regRdata_r;

  a_run_gated_start: assert property (@(posedge ref_clk) disable iff (reset)
    (state_r == ST_WAIT && state_nxt == ST_RUN) |-> ptIf.done && ostIf.done && !pinLow)
    else $error("core released before start-up conditions");
  a_pin_release_run: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == ST_RUN && pinResetEnable && !pinPrev_r && pinS && !porS && !brownS
    |=> pcLoad && pcLoadAddr == PC_RESET && !coreHold)
    else $error("no immediate start on pin release");
  a_por_values: assert property (@(posedge ref_clk) disable iff (reset)
    porEvt |=> flags_r == FLAGS_POR_VALUE && timeout_status_n && powerdown_status_n)
    else $error("power-on values wrong");
  a_bor_flags: assert property (@(posedge ref_clk) disable iff (reset)
    brownEvt |=> !flags_r[FLG_OVF] && !flags_r[FLG_UNF] && flags_r[FLG_PIN_N]
    && flags_r[FLG_INSTR_N] && !flags_r[FLG_BROWN_N]
    && flags_r[FLG_POR_N] == $past(flags_r[FLG_POR_N]) && timeout_status_n)
    else $error("brown-out flags wrong");
  a_pin_flag: assert property (@(posedge ref_clk) disable iff (reset)
    pinEvt && !porS && !brownS |=> !flags_r[FLG_PIN_N])
    else $error("pin reset flag not cleared");
  a_instr_flag: assert property (@(posedge ref_clk) disable iff (reset)
    instrEvt && !porS && !brownS |=> !flags_r[FLG_INSTR_N] && pcLoad)
    else $error("instruction reset not recorded");
  a_wdt_timeout: assert property (@(posedge ref_clk) disable iff (reset)
    wdtEvt && !porS && !brownS |=> !timeout_status_n)
    else $error("watchdog time-out bit not cleared");
  a_wake_vector: assert property (@(posedge ref_clk) disable iff (reset)
    wakeEvt && global_irq_enable && !wdtEvt && !porS && !brownS ##1 running
    |-> resumeNext ##1 pcLoad && pcLoadAddr == PC_VECTOR)
    else $error("interrupt wake did not vector");
  a_stack_gate: assert property (@(posedge ref_clk) disable iff (reset)
    running && stackOverflow && !stack_reset_enable && !flagWr && !porS && !brownS
    |=> flags_r[FLG_OVF] == $past(flags_r[FLG_OVF]))
    else $error("stack flag set while disabled");
  a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (reset)
    regRd && regAddr == ADDR_FLAGS |=> regRdata[5:4] == 2'h0)
    else $error("unimplemented bits not zero");
endmodule

// file: dv/rcs_pin_model.sv
/*
  External reset pin driver beside the board pull-up.
  Assumes holdLow changes just after a rising edge of the bench clock.
*/
`timescale 1ns/1ns
module rcs_pin_model (
  input wire logic holdLow,
  output logic pinLevel
);
  // Open drain: a released pin rests at the pull-up level
  assign pinLevel = holdLow ? 1'b0 : 1'b1;
endmodule

// file: dv/rcs_reset_cause_startup_test.sv
/*
  Bench for the reset-cause and start-up block: register tasks, core
  event pulses and start-up gating checks.
  Assumes the package, interface, design files and pin model come first.
*/
`timescale 1ns/1ns
module rcs_reset_cause_startup_test;
  import rcs_pkg::*;
  // Short timers keep the run brief
  localparam int PU = 20;
  localparam int OS = 8;
  logic ref_clk = 0, reset = 1, regWr = 0, regRd = 0, holdLow = 1, pinLevel;
  logic [REG_AW-1:0] regAddr = '0;
  logic [REG_DW-1:0] regWdata = '0, regRdata;
  logic porActive = 1, brownoutActive = 0, sleepActive = 0, stkEn = 0, irqEnable = 0;
  logic pinEn = 1, tmrEn = 1;
  logic wdtExpire = 0, resetInstr = 0, stackOverflow = 0, stackUnderflow = 0;
  logic irqWake = 0, coreHold, pcLoad, resumeNext, toN, downN, irq;
  logic [15:0] pcLoadAddr;
  int bad_count = 0;
  int compares = 0;

  rcs_pin_model pin (.holdLow(holdLow), .pinLevel(pinLevel));
  rcs_reset_cause_startup #(.POWERUP_CYCLES(PU), .OSC_START_CYCLES(OS)) dut (
    .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .porActive(porActive),
    .brownoutActive(brownoutActive), .external_reset_pin_n(pinLevel),
    .pinResetEnable(pinEn), .powerup_timer_en(tmrEn), .oscStartRequired(tmrEn),
    .stack_reset_enable(stkEn),
    .global_irq_enable(irqEnable), .sleepActive(sleepActive), .wdtExpire(wdtExpire),
    .resetInstr(resetInstr), .stackOverflow(stackOverflow),
    .stackUnderflow(stackUnderflow), .irqWake(irqWake), .coreHold(coreHold),
    .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .resumeNext(resumeNext),
    .timeout_status_n(toN), .powerdown_status_n(downN), .irq(irq));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask

  task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] exp,
                    input string what);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk({8'h00, regRdata}, {8'h00, exp}, what);
  endtask

  task automatic ev(input int k);
    @(posedge ref_clk);
    case (k)
      0: wdtExpire <= 1'b1;
      1: resetInstr <= 1'b1;
      2: stackOverflow <= 1'b1;
      3: stackUnderflow <= 1'b1;
      5: begin
        resetInstr <= 1'b1;
        stackOverflow <= 1'b1;
      end
      default: irqWake <= 1'b1;
    endcase
    @(posedge ref_clk);
    {wdtExpire, resetInstr, stackOverflow, stackUnderflow, irqWake} <= 5'h00;
  endtask

  // Events are ignored while held, so each restart waits for the core to run
  task automatic waitPc(input logic [15:0] exp, input int maxc, input string what);
    // The pulse stands one cycle from the calling edge, so look before waiting
    repeat (maxc) begin
      #1;
      if (pcLoad === 1'b1) break;
      @(posedge ref_clk);
    end
    chk({15'h0000, pcLoad}, 16'h0001, what);
    chk(pcLoadAddr, exp, what);
    repeat (8) begin
      if (coreHold === 1'b0) break;
      @(posedge ref_clk);
      #1;
    end
  endtask

  task automatic waitResume(input string what);
    repeat (4) begin
      #1;
      if (resumeNext === 1'b1) break;
      @(posedge ref_clk);
    end
    chk({15'h0000, resumeNext}, 16'h0001, what);
  endtask

  task automatic pinRst(input logic [REG_DW-1:0] st, input string what);
    @(posedge ref_clk);
    holdLow <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 chk({15'h0000, coreHold}, 16'h0001, what);
    rd(ADDR_STATUS, st, what);
    @(posedge ref_clk);
    holdLow <= 1'b0;
    waitPc(PC_RESET, 8, what);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    porActive <= 1'b0;
    rd(ADDR_FLAGS, FLAGS_POR_VALUE, "power-on flags");
    rd(ADDR_STATUS, 8'h18, "power-on status");
    repeat (PU + OS + 20) @(posedge ref_clk);
    #1 chk({15'h0000, coreHold}, 16'h0001, "held by pin");
    @(posedge ref_clk);
    holdLow <= 1'b0;
    waitPc(PC_RESET, 6, "start at pin release");
    done("startup");
    wr(ADDR_FLAGS, 8'hFF);
    rd(ADDR_FLAGS, FLAGS_IMPL_MASK, "flags all written");
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'h18, "status read only");
    wr(ADDR_FLAGS, 8'hC3);
    @(posedge ref_clk);
    brownoutActive <= 1'b1;
    repeat (6) @(posedge ref_clk);
    brownoutActive <= 1'b0;
    rd(ADDR_FLAGS, 8'h0E, "brown-out flags");
    rd(ADDR_STATUS, 8'h18, "brown-out status");
    waitPc(PC_RESET, PU + OS + 20, "brown-out restart");
    done("flags and brown-out");
    ev(1);
    waitPc(PC_RESET, 4, "instruction restart");
    rd(ADDR_FLAGS, 8'h0A, "instruction flags");
    ev(2);
    rd(ADDR_FLAGS, 8'h0A, "stack fault disabled");
    @(posedge ref_clk);
    stkEn <= 1'b1;
    ev(2);
    waitPc(PC_RESET, 4, "overflow restart");
    ev(3);
    waitPc(PC_RESET, 4, "underflow restart");
    rd(ADDR_FLAGS, 8'hCA, "stack flags");
    done("instruction and stack");
    ev(0);
    waitPc(PC_RESET, 4, "watchdog restart");
    rd(ADDR_STATUS, 8'h08, "watchdog status");
    pinRst(8'h08, "pin reset awake");
    rd(ADDR_FLAGS, 8'hC2, "pin flag");
    done("watchdog and pin");
    @(posedge ref_clk);
    sleepActive <= 1'b1;
    irqEnable <= 1'b1;
    ev(4);
    waitResume("interrupt wake");
    waitPc(PC_VECTOR, 2, "interrupt vector");
    rd(ADDR_STATUS, 8'h10, "interrupt wake status");
    ev(0);
    waitResume("watchdog wake");
    rd(ADDR_STATUS, 8'h00, "watchdog wake status");
    pinRst(8'h10, "pin reset asleep");
    done("sleep wakes");
    rd(ADDR_INT_STAT, 8'h7F, "event status");
    #1 chk({15'h0000, irq}, 16'h0000, "masked interrupt");
    wr(ADDR_INT_MASK, 8'h04);
    #1 chk({15'h0000, irq}, 16'h0001, "unmasked interrupt");
    wr(ADDR_INT_STAT, 8'h7F);
    rd(ADDR_INT_STAT, 8'h00, "event status cleared");
    #1 chk({15'h0000, irq}, 16'h0000, "interrupt cleared");
    done("interrupts");
    @(posedge ref_clk);
    sleepActive <= 1'b0;
    irqEnable <= 1'b0;
    wr(ADDR_FLAGS, 8'h0F);
    ev(5);
    waitPc(PC_RESET, 4, "coincident restart");
    rd(ADDR_FLAGS, 8'h8B, "coincident flags");
    done("coincident causes");
    @(posedge ref_clk);
    porActive <= 1'b1;
    holdLow <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk({15'h0000, coreHold}, 16'h0001, "held in power-on");
    rd(ADDR_FLAGS, FLAGS_POR_VALUE, "second power-on flags");
    rd(ADDR_STATUS, 8'h18, "second power-on status");
    // Timers and pin gating off: start must follow the release at once
    @(posedge ref_clk);
    porActive <= 1'b0;
    pinEn <= 1'b0;
    tmrEn <= 1'b0;
    waitPc(PC_RESET, 6, "start with gates disabled");
    done("second power-on");
    print_verdict();
  end
endmodule
